// ===== hw/power_sleep_transition_controller.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module power_sleep_transition_controller
    import pwr_seq_pkg::*;
#(
    parameter int WAIT_RESET_CYCLES = WAIT_RST_CYC,
    parameter logic [NUM_MODULES-1:0] CORE_MASK = 12'h038,
    parameter logic [NUM_MODULES-1:0] DEDICATED_CLK_MASK = 12'h6c0,
    parameter logic [NUM_MODULES-1:0] PERM_MODULE_MASK = 12'h838,
    parameter logic [4*NUM_MODULES-1:0] MOD_DOMAIN_MAP = 48'h0540_2100_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [NUM_DOMAINS-1:0] mem_sleep,
    output logic [NUM_MODULES-1:0] mod_clk_gate_en,
    output logic [NUM_MODULES-1:0] mod_clk_src_req,
    output logic [NUM_MODULES-1:0] mod_reset_n,
    output logic [NUM_MODULES-1:0] core_local_reset_n
);
    // ==========================================================
    // Bus decode
    logic wr_acc;
    logic [9:0] widx;
    assign wr_acc = psel & penable & pwrite;
    assign widx = paddr[11:2];
    assign pready = 1'b1;

    logic [NUM_DOMAINS-1:0] dom_next_ff;
    logic [2:0] mod_next_ff [NUM_MODULES];
    logic [NUM_MODULES-1:0] lrst_sw_ff;
    logic [4:0] emu_ff;
    logic [NUM_DOMAINS-1:0] dom_on_ff;
    logic [NUM_MODULES-1:0] mod_en_ff;
    logic [NUM_MODULES-1:0] mod_clk_ff;
    logic [NUM_DOMAINS-1:0] pend_ff;
    logic [NUM_DOMAINS-1:0] go_req;
    seq_state_t state_ff;
    logic [2:0] cur_dom_ff;
    logic [7:0] cnt_ff;
    logic [NUM_MODULES-1:0] want_en;

    function automatic logic [2:0] mod_dom(input int m);
        mod_dom = MOD_DOMAIN_MAP[4*m +: 3];
    endfunction

    function automatic logic dom_index_ok(input logic [9:0] idx, input logic [9:0] base);
        dom_index_ok = (idx >= base) && (idx < base + 10'(NUM_DOMAINS));
    endfunction

    // ==========================================================
    // Software control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dom_next_ff <= '0;
            lrst_sw_ff <= '0;
            emu_ff <= '0;
            for (int m = 0; m < NUM_MODULES; m++) begin
                mod_next_ff[m] <= MOD_DIS_CODE;
            end
        end else if (wr_acc) begin
            if (dom_index_ok(widx, 10'(DCTL_BASE >> 2))) begin
                dom_next_ff[3'(widx - 10'(DCTL_BASE >> 2))] <= (pwdata[3:0] == DOM_ON_CODE);
            end
            if (widx == 10'(EMU_OFFS >> 2)) begin
                emu_ff <= pwdata[4:0];
            end
            for (int m = 0; m < NUM_MODULES; m++) begin
                if (widx == 10'(MCTL_BASE >> 2) + 10'(m)) begin
                    mod_next_ff[m] <= pwdata[MCTL_NEXT_LSB +: 3];
                    if (CORE_MASK[m]) begin
                        lrst_sw_ff[m] <= ~pwdata[MCTL_LRST_BIT];
                    end
                end
            end
        end
    end

    // Go strobes; a go while pending is ignored since software must wait.
    always_comb begin
        go_req = '0;
        if (wr_acc && widx == 10'(GO_OFFS >> 2)) begin
            go_req = pwdata[NUM_DOMAINS-1:0] & ~pend_ff;
        end
    end

    // ==========================================================
    // Pending flags: set on go, cleared by sequencer; set wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= '0;
        end else begin
            for (int d = 0; d < NUM_DOMAINS; d++) begin
                if (go_req[d]) begin
                    pend_ff[d] <= 1'b1;
                end else if (state_ff == SQ_DONE && cur_dom_ff == 3'(d)) begin
                    pend_ff[d] <= 1'b0;
                end
            end
        end
    end

    // Modules of the current domain whose enable is requested.
    always_comb begin
        want_en = '0;
        for (int m = 0; m < NUM_MODULES; m++) begin
            if (mod_dom(m) == cur_dom_ff && mod_next_ff[m] == MOD_EN_CODE && !mod_en_ff[m]) begin
                want_en[m] = 1'b1;
            end
        end
    end

    // ==========================================================
    // Sequencer: wake memory, start clock, release reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= SQ_IDLE;
            cur_dom_ff <= '0;
            cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                SQ_IDLE: begin
                    for (int d = NUM_DOMAINS - 1; d >= 0; d--) begin
                        if (pend_ff[d]) begin
                            cur_dom_ff <= 3'(d);
                            state_ff <= SQ_WAKE;
                            cnt_ff <= 8'(WAKE_CYC);
                        end
                    end
                end
                SQ_WAKE: begin
                    if (dom_on_ff[cur_dom_ff] || cnt_ff == 8'h01) begin
                        state_ff <= SQ_CLK;
                        cnt_ff <= 8'(STEP_CYC);
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                SQ_CLK: begin
                    if (want_en == '0 || cnt_ff == 8'h01) begin
                        state_ff <= SQ_RST;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                SQ_RST: state_ff <= SQ_DONE;
                SQ_DONE: state_ff <= SQ_IDLE;
                default: state_ff <= SQ_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Domain power state: only ever OFF to ON.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dom_on_ff <= DOM_ON_RESET;
        end else begin
            for (int d = 0; d < NUM_DOMAINS; d++) begin
                if ((state_ff == SQ_WAKE && cur_dom_ff == 3'(d) && dom_next_ff[d]) ||
                    emu_ff[EMU_FPWR_BIT] || emu_ff[EMU_FACT_BIT]) begin
                    dom_on_ff[d] <= 1'b1;
                end
            end
        end
    end

    // Clock then reset, per module; enabled is sticky.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_clk_ff <= PERM_MODULE_MASK;
            mod_en_ff <= PERM_MODULE_MASK;
        end else begin
            for (int m = 0; m < NUM_MODULES; m++) begin
                if ((state_ff == SQ_CLK && want_en[m]) || emu_ff[EMU_FACT_BIT]) begin
                    mod_clk_ff[m] <= 1'b1;
                end
                if ((state_ff == SQ_RST && want_en[m] && mod_clk_ff[m]) ||
                    (emu_ff[EMU_FACT_BIT] && mod_clk_ff[m])) begin
                    mod_en_ff[m] <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Local reset with emulation assert, wait and block.
    logic [NUM_MODULES-1:0] lrst_ff;
    logic [15:0] wait_cnt_ff [NUM_MODULES];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lrst_ff <= '0;
            for (int m = 0; m < NUM_MODULES; m++) begin
                wait_cnt_ff[m] <= '0;
            end
        end else begin
            for (int m = 0; m < NUM_MODULES; m++) begin
                if (!CORE_MASK[m]) begin
                    lrst_ff[m] <= 1'b0;
                end else if (emu_ff[EMU_ARST_BIT] || (lrst_sw_ff[m] && !emu_ff[EMU_BRST_BIT])) begin
                    lrst_ff[m] <= 1'b1;
                    wait_cnt_ff[m] <= emu_ff[EMU_WRST_BIT] ? 16'(WAIT_RESET_CYCLES) : 16'h0000;
                end else if (wait_cnt_ff[m] != 16'h0000) begin
                    wait_cnt_ff[m] <= wait_cnt_ff[m] - 16'h0001;
                end else begin
                    lrst_ff[m] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Outputs to memories, clock controller and modules.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_sleep <= ~DOM_ON_RESET;
            mod_clk_gate_en <= PERM_MODULE_MASK & ~DEDICATED_CLK_MASK;
            mod_clk_src_req <= PERM_MODULE_MASK & DEDICATED_CLK_MASK;
            mod_reset_n <= PERM_MODULE_MASK;
            core_local_reset_n <= '1;
        end else begin
            mem_sleep <= ~dom_on_ff;
            mod_clk_gate_en <= mod_clk_ff & ~DEDICATED_CLK_MASK;
            mod_clk_src_req <= mod_clk_ff & DEDICATED_CLK_MASK;
            mod_reset_n <= mod_en_ff;
            core_local_reset_n <= ~lrst_ff;
        end
    end

    // ==========================================================
    // Read path; unmapped addresses read zero without error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= '0;
            if (paddr == ID_OFFS) prdata <= ID_VALUE;
            if (paddr == PEND_OFFS) prdata <= 32'(pend_ff);
            if (paddr == DSTAT_OFFS) prdata <= 32'(dom_on_ff);
            if (paddr == EMU_OFFS) prdata <= 32'(emu_ff);
            for (int d = 0; d < NUM_DOMAINS; d++) begin
                if (paddr[11:2] == 10'(DCTL_BASE >> 2) + 10'(d)) prdata <= 32'(dom_next_ff[d]);
            end
            for (int m = 0; m < NUM_MODULES; m++) begin
                if (paddr[11:2] == 10'(MSTAT_BASE >> 2) + 10'(m)) begin
                    prdata <= {23'h0, ~lrst_ff[m], 5'h0, (mod_en_ff[m] ? MOD_EN_CODE : MOD_DIS_CODE)};
                end
                if (paddr[11:2] == 10'(MCTL_BASE >> 2) + 10'(m)) begin
                    prdata <= {23'h0, ~lrst_sw_ff[m], 5'h0, mod_next_ff[m]};
                end
            end
        end
    end
    assign pslverr = 1'b0;

    // ==========================================================
    // Checks
    a_perm_dom_on: assert property (@(posedge pclk) disable iff (!presetn) dom_on_ff[PERM_DOMAIN])
        else $error("Permanent domain not on.");
    a_dom_never_off: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(dom_on_ff) & ~dom_on_ff) == '0)
        else $error("Domain went off.");
    a_mod_never_dis: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(mod_en_ff) & ~mod_en_ff) == '0)
        else $error("Module left enabled.");
    a_en_after_clk: assert property (@(posedge pclk) disable iff (!presetn)
        (mod_en_ff & ~mod_clk_ff) == '0)
        else $error("Module enabled without clock.");
    a_wake_first: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == SQ_CLK |-> dom_on_ff[cur_dom_ff] || !dom_next_ff[cur_dom_ff])
        else $error("Clock started before wake.");
    a_go_sets_pend: assert property (@(posedge pclk) disable iff (!presetn)
        go_req != '0 |=> (pend_ff & $past(go_req)) == $past(go_req))
        else $error("Go did not set pending.");
    a_pend_clears: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pend_ff[1]) |-> ##[1:40] !pend_ff[1])
        else $error("Pending stuck.");
    a_lrst_block: assert property (@(posedge pclk) disable iff (!presetn)
        emu_ff[EMU_BRST_BIT] && !emu_ff[EMU_ARST_BIT] && lrst_ff == '0 |=> lrst_ff == '0)
        else $error("Blocked reset asserted.");
    a_lrst_core: assert property (@(posedge pclk) disable iff (!presetn)
        (lrst_ff & ~CORE_MASK) == '0)
        else $error("Local reset on non-core.");
    c_go: cover property (@(posedge pclk) disable iff (!presetn) go_req != '0);
    c_enable: cover property (@(posedge pclk) disable iff (!presetn) $rose(mod_en_ff[6]));
    c_lrst: cover property (@(posedge pclk) disable iff (!presetn) $fell(lrst_ff[3]));
    c_wake: cover property (@(posedge pclk) disable iff (!presetn)
        state_ff == SQ_WAKE && !dom_on_ff[cur_dom_ff]);
    c_force: cover property (@(posedge pclk) disable iff (!presetn) $rose(emu_ff[EMU_FACT_BIT]));

    // ==========================================================
    // Sequencer and emulation checks
    // These assume software keeps a module's request fixed while its domain is pending.
    a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == SQ_DONE |=> !pend_ff[cur_dom_ff])
        else $error("Pending not cleared at done.");
    a_on_wakes: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == SQ_WAKE && dom_next_ff[cur_dom_ff] |=> dom_on_ff[cur_dom_ff])
        else $error("On request did not wake domain.");
    a_clk_before_rst: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == SQ_RST |-> (want_en & ~mod_clk_ff) == '0)
        else $error("Reset step reached before clock.");
    a_force_power: assert property (@(posedge pclk) disable iff (!presetn)
        emu_ff[EMU_FPWR_BIT] |=> dom_on_ff == '1)
        else $error("Force power did not wake domains.");
    a_force_active: assert property (@(posedge pclk) disable iff (!presetn)
        emu_ff[EMU_FACT_BIT] |=> mod_clk_ff == '1)
        else $error("Force active did not start clocks.");
    a_emu_assert: assert property (@(posedge pclk) disable iff (!presetn)
        emu_ff[EMU_ARST_BIT] |=> (lrst_ff & CORE_MASK) == CORE_MASK)
        else $error("Emulation reset not asserted.");

    // ==========================================================
    // Pin checks
    // Every output except pready and pslverr is registered, so the pins trail the state by one cycle.
    a_sleep_pins: assert property (@(posedge pclk) disable iff (!presetn)
        mem_sleep == ~$past(dom_on_ff))
        else $error("Sleep pins do not follow domain state.");
    a_lrst_pins: assert property (@(posedge pclk) disable iff (!presetn)
        core_local_reset_n == ~$past(lrst_ff))
        else $error("Local reset pins do not follow state.");
    a_core_pins_only: assert property (@(posedge pclk) disable iff (!presetn)
        (~core_local_reset_n & ~CORE_MASK) == '0)
        else $error("Local reset pin low on non-core.");
    a_clk_split: assert property (@(posedge pclk) disable iff (!presetn)
        (mod_clk_gate_en & mod_clk_src_req) == '0)
        else $error("Clock both gated and requested.");
    a_src_dedicated: assert property (@(posedge pclk) disable iff (!presetn)
        (mod_clk_src_req & ~DEDICATED_CLK_MASK) == '0)
        else $error("Clock request for shared-clock module.");
    a_gate_shared: assert property (@(posedge pclk) disable iff (!presetn)
        (mod_clk_gate_en & DEDICATED_CLK_MASK) == '0)
        else $error("Local gate used for dedicated clock.");
    a_rst_needs_clk: assert property (@(posedge pclk) disable iff (!presetn)
        (mod_reset_n & ~(mod_clk_gate_en | mod_clk_src_req)) == '0)
        else $error("Module reset released with clock off.");
    a_rst_pins_kept: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(mod_reset_n) & ~mod_reset_n) == '0)
        else $error("Module reset pin asserted again.");
    a_perm_mods_on: assert property (@(posedge pclk) disable iff (!presetn)
        (mod_reset_n & PERM_MODULE_MASK) == PERM_MODULE_MASK)
        else $error("Permanent module held in reset.");
endmodule // power_sleep_transition_controller

`default_nettype wire

// ===== hw/pwr_seq_pkg.sv
`default_nettype none
package pwr_seq_pkg;
    // ==========================================================
    // Geometry
    localparam int NUM_DOMAINS = 6;
    localparam int NUM_MODULES = 12;
    localparam int PERM_DOMAIN = 0;
    // ==========================================================
    // Register byte offsets (APB, one aligned word each)
    localparam logic [11:0] ID_OFFS = 12'h000;
    localparam logic [11:0] GO_OFFS = 12'h120;
    localparam logic [11:0] PEND_OFFS = 12'h128;
    localparam logic [11:0] DSTAT_OFFS = 12'h200;
    localparam logic [11:0] DCTL_BASE = 12'h300;
    localparam logic [11:0] MSTAT_BASE = 12'h800;
    localparam logic [11:0] MCTL_BASE = 12'ha00;
    localparam logic [11:0] EMU_OFFS = 12'h140;
    // ==========================================================
    // Field layouts and encodings
    localparam logic [3:0] DOM_ON_CODE = 4'h1;
    localparam logic [2:0] MOD_EN_CODE = 3'h3;
    localparam logic [2:0] MOD_DIS_CODE = 3'h0;
    localparam int MCTL_NEXT_LSB = 0;
    localparam int MCTL_LRST_BIT = 8;
    localparam int EMU_FPWR_BIT = 0;
    localparam int EMU_FACT_BIT = 1;
    localparam int EMU_ARST_BIT = 2;
    localparam int EMU_WRST_BIT = 3;
    localparam int EMU_BRST_BIT = 4;
    // ==========================================================
    // Reset values and arbitrary identification value
    localparam logic [31:0] ID_VALUE = 32'h0000_1234;
    localparam logic [NUM_DOMAINS-1:0] DOM_ON_RESET = 6'h01;
    // ==========================================================
    // Timing
    localparam int CLK_NS = 25;
    localparam int WAKE_NS = 200;
    localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_NS = 50;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAIT_RST_NS = 2000;
    localparam int WAIT_RST_CYC = (WAIT_RST_NS + CLK_NS - 1) / CLK_NS;
    // ==========================================================
    // Sequencer states
    typedef enum logic [4:0] {
        SQ_IDLE = 5'h01,
        SQ_WAKE = 5'h02,
        SQ_CLK = 5'h04,
        SQ_RST = 5'h08,
        SQ_DONE = 5'h10
    } seq_state_t;
endpackage
`default_nettype wire

// ===== sim/gated_module_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side: gated modules, their memories and clock source.
module gated_module_model
    import pwr_seq_pkg::*;
#(
    parameter logic [4*NUM_MODULES-1:0] MOD_DOMAIN_MAP = 48'h0540_2100_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM_DOMAINS-1:0] mem_sleep,
    input wire logic [NUM_MODULES-1:0] mod_clk_gate_en,
    input wire logic [NUM_MODULES-1:0] mod_clk_src_req,
    input wire logic [NUM_MODULES-1:0] mod_reset_n,
    output var logic [7:0] fault_count_ff
);
    // A fault is counted each cycle, so a glitch in order is never missed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_count_ff <= 8'h00;
        end else begin
            for (int m = 0; m < NUM_MODULES; m++) begin
                // Clock runs from the local gate or the source request.
                if (mod_reset_n[m] && !(mod_clk_gate_en[m] || mod_clk_src_req[m])) begin
                    fault_count_ff <= fault_count_ff + 8'h01;
                end
                if ((mod_clk_gate_en[m] || mod_clk_src_req[m]) && mem_sleep[MOD_DOMAIN_MAP[4*m+:3]]) begin
                    fault_count_ff <= fault_count_ff + 8'h01;
                end
            end
        end
    end
endmodule // gated_module_model
`default_nettype wire

// ===== sim/power_sleep_transition_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
module power_sleep_transition_controller_test
    import pwr_seq_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_DOMAINS-1:0] mem_sleep;
    logic [NUM_MODULES-1:0] mod_clk_gate_en;
    logic [NUM_MODULES-1:0] mod_clk_src_req;
    logic [NUM_MODULES-1:0] mod_reset_n;
    logic [NUM_MODULES-1:0] core_local_reset_n;
    logic [7:0] fault_count;
    logic [31:0] rd;
    int errors = 0;
    int total_checks = 0;
    int n;
    localparam logic [NUM_MODULES-1:0] CORE_MASK_C = 12'h038;
    // ==========================================================
    // Design and far side
    power_sleep_transition_controller #(.WAIT_RESET_CYCLES(16)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_sleep(mem_sleep),
        .mod_clk_gate_en(mod_clk_gate_en), .mod_clk_src_req(mod_clk_src_req),
        .mod_reset_n(mod_reset_n), .core_local_reset_n(core_local_reset_n));
    gated_module_model far_side (.pclk(pclk), .presetn(presetn), .mem_sleep(mem_sleep),
        .mod_clk_gate_en(mod_clk_gate_en), .mod_clk_src_req(mod_clk_src_req),
        .mod_reset_n(mod_reset_n), .fault_count_ff(fault_count));
    always #12.5 pclk = ~pclk;
    // ==========================================================
    // Tasks
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // The extra idle edge at the end keeps back-to-back calls from
    // assigning psel twice in one time step.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            errors++;
            give_verdict();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(what, e, rd & m);
    endtask
    // Software waits for the pending flag before a new go.
    task automatic wait_idle(input int d);
        int k;
        k = 0;
        do begin
            apb(1'b0, PEND_OFFS, 32'h0);
            k++;
        end while (rd[d] !== 1'b0 && k < 60);
        check("pending done", 32'h0, {31'h0, rd[d]});
    endtask
    task automatic go(input int d, input int m, input logic [31:0] dn, input logic [31:0] mn);
        wait_idle(d);
        apb(1'b1, DCTL_BASE + 12'(4 * d), dn);
        apb(1'b1, MCTL_BASE + 12'(4 * m), mn);
        apb(1'b1, GO_OFFS, 32'h1 << d);
        apb(1'b0, PEND_OFFS, 32'h0);
        check("pending set", 32'h1, {31'h0, rd[d]});
        wait_idle(d);
    endtask
    task automatic wait_out(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("id", ID_OFFS, 32'hffff_ffff, ID_VALUE);
        rchk("dstat reset", DSTAT_OFFS, 32'h3f, 32'h01);
        rchk("pend reset", PEND_OFFS, 32'h3f, 32'h0);
        rchk("unmapped", 12'h0f0, 32'hffff_ffff, 32'h0);
        check("sleep reset", 32'h3e, 32'(mem_sleep));
        check("mod rst reset", 32'h838, 32'(mod_reset_n & 12'hef8));
        // Domains one at a time, each with its module in the same go.
        go(1, 6, 32'h1, 32'h3);
        go(2, 7, 32'h1, 32'h3);
        go(4, 9, 32'h1, 32'h3);
        rchk("dstat on", DSTAT_OFFS, 32'h3f, 32'h17);
        rchk("mstat6", MSTAT_BASE + 12'h018, 32'h7, 32'h3);
        check("sleep on", 32'h28, 32'(mem_sleep));
        check("mod on", 32'haf8, 32'(mod_reset_n & 12'hef8));
        check("src req", 32'h2c0, 32'(mod_clk_src_req & 12'h6c0));
        check("gate en", 32'h838, 32'(mod_clk_gate_en & 12'hef8));
        // Same states again, then an illegal downward request.
        go(1, 6, 32'h1, 32'h3);
        go(1, 6, 32'h0, 32'h0);
        rchk("dstat kept", DSTAT_OFFS, 32'h3f, 32'h17);
        check("mod kept", 32'h1, 32'(mod_reset_n[6]));
        // Local reset of one core only.
        apb(1'b1, MCTL_BASE + 12'h00c, 32'h003);
        wait_out(2);
        check("lrst assert", 32'h030, 32'(core_local_reset_n & CORE_MASK_C));
        check("core mod rst", 32'h038, 32'(mod_reset_n & 12'h038));
        rchk("mstat3 lrst", MSTAT_BASE + 12'h00c, 32'h100, 32'h0);
        apb(1'b1, MCTL_BASE + 12'h00c, 32'h103);
        wait_out(2);
        check("lrst release", 32'h038, 32'(core_local_reset_n & CORE_MASK_C));
        // Wait-reset stretches the release.
        apb(1'b1, EMU_OFFS, 32'h08);
        apb(1'b1, MCTL_BASE + 12'h00c, 32'h003);
        apb(1'b1, MCTL_BASE + 12'h00c, 32'h103);
        wait_out(1);
        check("wait rst held", 32'h0, 32'(core_local_reset_n[3]));
        wait_out(24);
        check("wait rst done", 32'h1, 32'(core_local_reset_n[3]));
        // Assert-reset, then block-reset against software.
        apb(1'b1, EMU_OFFS, 32'h04);
        wait_out(2);
        check("emu assert", 32'h0, 32'(core_local_reset_n[5]));
        apb(1'b1, EMU_OFFS, 32'h10);
        apb(1'b1, MCTL_BASE + 12'h010, 32'h003);
        wait_out(2);
        check("blocked", 32'h1, 32'(core_local_reset_n[4]));
        apb(1'b1, MCTL_BASE + 12'h010, 32'h103);
        // Force power, then force active, checked on domain 5, the higher of the two sleeping domains.
        apb(1'b1, EMU_OFFS, 32'h01);
        n = 0;
        while (mem_sleep[5] !== 1'b0 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        wait_out(4);
        check("force pwr", 32'h0, 32'(mem_sleep[5]));
        check("force pwr mod", 32'h0, 32'(mod_reset_n[10]));
        apb(1'b1, EMU_OFFS, 32'h03);
        n = 0;
        while (mod_reset_n[10] !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        check("force act", 32'h1, 32'(mod_reset_n[10]));
        apb(1'b1, EMU_OFFS, 32'h00);
        check("order faults", 32'h0, 32'(fault_count));
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        give_verdict();
    end
endmodule // power_sleep_transition_controller_test
`default_nettype wire
